// [include/fault_report_params.svh]
// Constants of the fault-reporting latch: frame layout, readback fields,
// register offsets, field positions and reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FAULT_REPORT_PARAMS_SVH
`define FAULT_REPORT_PARAMS_SVH

// ----------------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------------
`define FRAME_BITS        5'h10
`define FRAME_LAST_IDX    5'h0f
`define FRAME_CNT_MAX     5'h1f
`define CMD_SEEN_CNT      5'h04
`define CMD_READ_FAULT    3'h4

// ----------------------------------------------------------------------
// Readback word and fault lanes
// ----------------------------------------------------------------------
`define NUM_FAULTS        4
`define FAULT_BROWNOUT    0
`define FAULT_OVERTEMP    1
`define FAULT_OPEN_LOAD   2
`define FAULT_SHORT       3
`define OUTPUT_FAULTS     4'hc
`define RB_INT_BIT        9
`define RB_FAULT_LSB      5

// ----------------------------------------------------------------------
// Synchroniser bank: {fault pin, faults, data in, select, serial clock}
// ----------------------------------------------------------------------
`define SYNC_W            8
`define SYNC_RESET        8'h82
`define SYNC_SCLK         0
`define SYNC_CS           1
`define SYNC_DIN          2
`define SYNC_FAULT_LSB    3
`define SYNC_PIN          7

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define REG_ADDR_W        8
`define REG_STATUS        8'h00
`define REG_MASK          8'h04
`define REG_FAULT_STATE   8'h08
`define REG_CTRL          8'h0c
`define EVT_FAULT         0
`define EVT_READ          1
`define EVT_ABORT         2
`define EVT_W             3
`define CTRL_PIN_EN       0
`define CTRL_RESET        1'b1
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [include/fault_report_pkg.sv]
// Types shared by the fault-reporting latch modules.
// Assumes the constants header sits on the include path.
`default_nettype none
`include "fault_report_params.svh"

package fault_report_pkg;
   typedef enum logic {FRAME_IDLE, FRAME_SHIFT} frame_state_t;
   typedef logic [`NUM_FAULTS-1:0] fault_vec_t;
   typedef logic [`EVT_W-1:0]      event_vec_t;
endpackage

`default_nettype wire

// [design/link_sync.sv]
// Bank of two-flop synchronisers with edge pulses on the settled level.
// Assumes each input is asynchronous to aclk and stays put for several
// aclk periods between edges.
`default_nettype none

module link_sync #(
   parameter int           W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Asynchronous inputs
   input  wire logic [W-1:0] async_in,
   // Settled level and one-cycle edge pulses
   output logic      [W-1:0] level,
   output logic      [W-1:0] rise,
   output logic      [W-1:0] fall
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;
   logic [W-1:0] last_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // Idle levels at reset keep a select line from faking an edge.
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               meta_reg[i] <= RESET_VAL[i];
               sync_reg[i] <= RESET_VAL[i];
               last_reg[i] <= RESET_VAL[i];
            end else begin
               meta_reg[i] <= async_in[i];
               sync_reg[i] <= meta_reg[i];
               last_reg[i] <= sync_reg[i];
            end
         end
         assign level[i] = sync_reg[i];
         assign rise[i]  = sync_reg[i] && !last_reg[i];
         assign fall[i]  = !sync_reg[i] && last_reg[i];
      end
   endgenerate
endmodule

`default_nettype wire

// [design/fault_lane.sv]
// Latch, re-arm mask and intermittent tracking of one fault type.
// Assumes a settled detector level and a one-cycle strobe per completed
// fault readback frame, both on aclk.
`default_nettype none

module fault_lane #(
   parameter bit OUTPUT_FAULT = 1'b0
) (
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Detector level and read cycle strobe
   input  wire logic raw,
   input  wire logic read_cycle,
   // Lane state towards the frame logic
   output logic      irq_req,
   output logic      report,
   output logic      intermittent,
   output logic      detect,
   output logic      latched,
   output logic      masked
);
   logic latch_reg;
   logic first_read_reg;
   logic mask_reg;
   logic gone_reg;

   assign detect       = raw && !latch_reg && !mask_reg;
   assign irq_req      = latch_reg && !first_read_reg;
   assign report       = latch_reg || (mask_reg && raw);
   assign intermittent = OUTPUT_FAULT && latch_reg
                         && (gone_reg || !raw);
   assign latched      = latch_reg;
   assign masked       = mask_reg;

   // A detection in the cycle of a read is kept: only the second read of
   // a latched fault clears, and then the mask takes the live level.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_reg      <= 1'b0;
         first_read_reg <= 1'b0;
         mask_reg       <= 1'b0;
         gone_reg       <= 1'b0;
      end else begin
         if (latch_reg && !raw) begin
            gone_reg <= 1'b1;
         end
         if (read_cycle && latch_reg) begin
            if (!first_read_reg) begin
               first_read_reg <= 1'b1;
            end else begin
               latch_reg      <= 1'b0;
               first_read_reg <= 1'b0;
               gone_reg       <= 1'b0;
               mask_reg       <= raw;
            end
         end else begin
            if (read_cycle && mask_reg && !raw) begin
               mask_reg <= 1'b0;
            end
            if (detect) begin
               latch_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_first_read;
      read_cycle && latch_reg && !first_read_reg;
   endsequence

   sequence s_second_read;
      read_cycle && latch_reg && first_read_reg;
   endsequence

   AST_DETECT_RAISES: assert property (detect |=> irq_req)
      else $error("new fault did not raise the interrupt request");
   AST_FIRST_READ: assert property (
      s_first_read |=> !irq_req && report)
      else $error("first read left request up or lost the report");
   AST_SECOND_CLEARS: assert property (
      s_second_read |=> !latch_reg && !first_read_reg)
      else $error("second read did not clear the latch");
   AST_MASKED_SILENT: assert property (
      mask_reg && raw && !read_cycle |=> !irq_req)
      else $error("masked unresolved fault raised the request again");
   AST_NO_INTERMIT: assert property (
      !OUTPUT_FAULT |-> !intermittent)
      else $error("non-output fault set the intermittent flag");
   AST_GONE_MARKED: assert property (
      latch_reg && first_read_reg && !raw && !read_cycle
      |=> !OUTPUT_FAULT || intermittent)
      else $error("vanished output fault not marked intermittent");
   AST_REARM: assert property (
      read_cycle && mask_reg && !latch_reg && !raw
      |=> !mask_reg ##1 (!$past(raw) || irq_req))
      else $error("resolved fault did not re-arm");
endmodule

`default_nettype wire

// [design/fault_report_latch.sv]
// Fault-reporting latch: serial readback slave, fault lanes, open-drain
// fault interrupt pin, and an AXI4-Lite register port for local software.
// Assumes the serial pins and fault detector levels are asynchronous to
// aclk and the serial clock is at most an eighth of the aclk rate.
//
// Notes on behaviour
// - Apart from new detections, fault state moves only with completed serial read frames, no free clock steps it.
// - A newly detected fault pulls the active-low fault pin low.
// - The first readback releases the pin and shows which fault is active.
// - The second readback still reports the fault, with the intermittent flag for output faults that have gone away.
// - Overtemperature and brownout never set the intermittent flag.
// - The second readback after a fault clears the latched contents.
// - Once removed and cleared, the next readback shows it resolved and re-arms it.
// - A fault gone before the first readback still reads active twice, output faults flagged intermittent.
// - An unresolved fault does not raise the pin again until resolved and reported.
// - A different fault type raises the pin even while another is masked.
// - Command 100 in data-in bits 13..11 returns the fault bits 9..5, bits 4..0 zero.
`default_nettype none
`include "fault_report_params.svh"

module fault_report_latch
   import fault_report_pkg::*;
(
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address and data
   input  wire logic [`REG_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   // AXI4-Lite write response
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   // AXI4-Lite read
   input  wire logic [`REG_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   // Serial link pins
   input  wire logic                   spi_sclk,
   input  wire logic                   spi_cs_n,
   input  wire logic                   spi_din,
   output logic                        spi_dout,
   output logic                        spi_dout_oe,
   // Open-drain fault interrupt pin
   input  wire logic                   fault_int_n_i,
   output logic                        fault_int_n_o,
   output logic                        fault_int_oe,
   // Fault detector levels
   input  wire logic [`NUM_FAULTS-1:0] fault_raw,
   // Local interrupt
   output logic                        irq
);
   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [`SYNC_W-1:0] sync_level;
   logic [`SYNC_W-1:0] sync_rise;
   logic [`SYNC_W-1:0] sync_fall;

   link_sync #(
      .W         (`SYNC_W),
      .RESET_VAL (`SYNC_RESET)
   ) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({fault_int_n_i, fault_raw, spi_din, spi_cs_n, spi_sclk}),
      .level    (sync_level),
      .rise     (sync_rise),
      .fall     (sync_fall)
   );

   wire       sclk_rise   = sync_rise[`SYNC_SCLK];
   wire       sclk_fall   = sync_fall[`SYNC_SCLK];
   wire       cs_low      = !sync_level[`SYNC_CS];
   wire       frame_start = sync_fall[`SYNC_CS];
   wire       frame_end   = sync_rise[`SYNC_CS];
   wire       din_bit     = sync_level[`SYNC_DIN];
   wire       pin_level   = sync_level[`SYNC_PIN];
   fault_vec_t fault_level;
   assign fault_level = sync_level[`SYNC_FAULT_LSB +: `NUM_FAULTS];

   // ----------------------------------------------------------------------
   // Fault lanes
   // ----------------------------------------------------------------------
   fault_vec_t lane_irq;
   fault_vec_t lane_report;
   fault_vec_t lane_intermit;
   fault_vec_t lane_detect;
   fault_vec_t lane_latched;
   fault_vec_t lane_masked;
   logic       read_cycle;

   genvar f;
   generate
      for (f = 0; f < `NUM_FAULTS; f++) begin : g_lane
         fault_lane #(
            .OUTPUT_FAULT (1'(`OUTPUT_FAULTS >> f))
         ) u_lane (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .raw          (fault_level[f]),
            .read_cycle   (read_cycle),
            .irq_req      (lane_irq[f]),
            .report       (lane_report[f]),
            .intermittent (lane_intermit[f]),
            .detect       (lane_detect[f]),
            .latched      (lane_latched[f]),
            .masked       (lane_masked[f])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Readback word
   // ----------------------------------------------------------------------
   wire        intermit_any = |lane_intermit;
   wire [15:0] rb_word = (16'(intermit_any) << `RB_INT_BIT)
                       | (16'(lane_report) << `RB_FAULT_LSB);

   // ----------------------------------------------------------------------
   // Serial frame engine
   // ----------------------------------------------------------------------
   // The readback is shifted out live during the frame while the read steps
   // of the lanes happen only at its end, so the word read is the state before the read.
   frame_state_t state_reg;
   frame_state_t state_next;
   logic [4:0]   cnt_reg;
   logic [1:0]   shift_reg;
   logic         hit_reg;
   logic         dout_reg;

   wire        frame_full = (cnt_reg == `FRAME_BITS);
   wire        in_shift   = (state_reg == FRAME_SHIFT);
   wire [3:0]  out_idx    = 4'(`FRAME_LAST_IDX - cnt_reg);
   wire        out_bit    = hit_reg && (cnt_reg < `FRAME_BITS)
                            && rb_word[out_idx];
   wire        cmd_match  = ({shift_reg, din_bit} == `CMD_READ_FAULT);
   wire        frame_abort = in_shift && frame_end
                             && !(frame_full && hit_reg);

   assign read_cycle = in_shift && frame_end && frame_full
                       && hit_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         FRAME_IDLE: begin
            if (frame_start) begin
               state_next = FRAME_SHIFT;
            end
         end
         FRAME_SHIFT: begin
            if (frame_end) begin
               state_next = FRAME_IDLE;
            end
         end
         default: state_next = FRAME_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= FRAME_IDLE;
         cnt_reg   <= '0;
         shift_reg <= '0;
         hit_reg   <= 1'b0;
         dout_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (frame_start) begin
            cnt_reg  <= '0;
            hit_reg  <= 1'b0;
            dout_reg <= 1'b0;
         end else if (in_shift && cs_low && sclk_rise) begin
            shift_reg <= {shift_reg[0], din_bit};
            if (cnt_reg != `FRAME_CNT_MAX) begin
               cnt_reg <= cnt_reg + 5'h01;
            end
            if (cnt_reg == `CMD_SEEN_CNT) begin
               hit_reg <= cmd_match;
            end
         end else if (in_shift && cs_low && sclk_fall) begin
            dout_reg <= out_bit;
         end
      end
   end

   assign spi_dout    = dout_reg;
   assign spi_dout_oe = in_shift;

   // ----------------------------------------------------------------------
   // Fault pin
   // ----------------------------------------------------------------------
   logic ctrl_reg;
   logic pin_oe_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_oe_reg <= 1'b0;
      end else begin
         pin_oe_reg <= (|lane_irq) && ctrl_reg;
      end
   end

   assign fault_int_n_o = 1'b0;
   assign fault_int_oe  = pin_oe_reg;

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   logic                   aw_have_reg;
   logic [`REG_ADDR_W-1:0] aw_addr_reg;
   logic                   w_have_reg;
   logic [31:0]            w_data_reg;
   logic                   w_lane0_reg;
   logic                   bvalid_reg;
   logic [1:0]             bresp_reg;
   logic                   rvalid_reg;
   logic [31:0]            rdata_reg;
   logic [1:0]             rresp_reg;
   event_vec_t             status_reg;
   event_vec_t             status_next;
   event_vec_t             mask_reg;

   assign awready = !aw_have_reg && !bvalid_reg;
   assign wready  = !w_have_reg && !bvalid_reg;
   assign arready = !rvalid_reg;

   wire do_write  = aw_have_reg && w_have_reg && !bvalid_reg;
   wire wr_lane   = do_write && w_lane0_reg;
   wire wr_status = wr_lane && (aw_addr_reg == `REG_STATUS);
   wire wr_mask   = wr_lane && (aw_addr_reg == `REG_MASK);
   wire wr_ctrl   = wr_lane && (aw_addr_reg == `REG_CTRL);
   wire wr_ok     = (aw_addr_reg == `REG_STATUS)
                    || (aw_addr_reg == `REG_MASK)
                    || (aw_addr_reg == `REG_FAULT_STATE)
                    || (aw_addr_reg == `REG_CTRL);

   wire rd_status = (araddr == `REG_STATUS);
   wire rd_mask   = (araddr == `REG_MASK);
   wire rd_state  = (araddr == `REG_FAULT_STATE);
   wire rd_ctrl   = (araddr == `REG_CTRL);
   wire rd_ok     = rd_status || rd_mask || rd_state || rd_ctrl;
   wire [31:0] rd_mux =
        rd_status ? 32'(status_reg)
      : rd_mask   ? 32'(mask_reg)
      : rd_state  ? 32'({pin_level, fault_level, lane_masked, lane_latched})
      : rd_ctrl   ? 32'(ctrl_reg)
      : 32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg  <= 1'b0;
         w_data_reg  <= '0;
         w_lane0_reg <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_have_reg  <= 1'b1;
            w_data_reg  <= wdata;
            w_lane0_reg <= wstrb[0];
         end
         if (do_write) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= `RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_reg && rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign bvalid = bvalid_reg;
   assign bresp  = bresp_reg;
   assign rvalid = rvalid_reg;
   assign rdata  = rdata_reg;
   assign rresp  = rresp_reg;

   // ----------------------------------------------------------------------
   // Registers and local interrupt
   // ----------------------------------------------------------------------
   // A new event in the cycle of a write-one-to-clear stays set.
   event_vec_t events;
   assign events[`EVT_FAULT] = |lane_detect;
   assign events[`EVT_READ]  = read_cycle;
   assign events[`EVT_ABORT] = frame_abort;
   assign status_next = (status_reg
                         & ~(wr_status ? w_data_reg[`EVT_W-1:0] : '0))
                        | events;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= '0;
         mask_reg   <= '0;
         ctrl_reg   <= `CTRL_RESET;
      end else begin
         status_reg <= status_next;
         if (wr_mask) begin
            mask_reg <= w_data_reg[`EVT_W-1:0];
         end
         if (wr_ctrl) begin
            ctrl_reg <= w_data_reg[`CTRL_PIN_EN];
         end
      end
   end

   assign irq = |(status_reg & mask_reg);

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_fault_frame_end;
      in_shift && frame_end && frame_full && hit_reg;
   endsequence

   AST_READ_ON_FRAME: assert property (
      !read_cycle |=> $stable(lane_masked))
      else $error("re-arm mask moved outside a readback frame");
   AST_NO_STEP_IDLE: assert property (
      !read_cycle |=> !(|($past(lane_latched) & ~lane_latched)))
      else $error("latch bit cleared outside a readback frame");
   AST_PIN_RAISED: assert property (
      $rose(|lane_irq) && ctrl_reg |=> fault_int_oe)
      else $error("fault pin not pulled low for a new fault");
   AST_PIN_RELEASED: assert property (
      s_fault_frame_end
      |=> ##1 !fault_int_oe || (|lane_irq))
      else $error("fault pin still low after the first readback");
   AST_RESERVED_ZERO: assert property (
      in_shift && cs_low && sclk_fall && (cnt_reg > 5'h0a)
      |=> !spi_dout)
      else $error("reserved readback bit driven high");
   AST_CMD_FILTER: assert property (
      in_shift && sclk_fall && !hit_reg |=> !spi_dout)
      else $error("readback bits sent for another command");
endmodule

`default_nettype wire

// [tb/host_model.sv]
// Host side of the serial link: runs one fault readback frame on request.
// Assumes the device drives its data line while the frame is open.
`default_nettype none
module host_model (
   // Serial link
   output logic     sclk,
   output logic     cs_n,
   output logic     din,
   input  wire logic dout
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      din  = 1'b1;
   end
   // The serial clock stands still between frames; 400 ns period inside.
   // Starts 10 ns off the aclk edge so no pin moves on a sampling edge.
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
      #10;
      cs_n = 1'b0;
      #200;
      for (int i = 15; i >= 0; i--) begin
         din = tx[i];
         #200 sclk = 1'b1;
         rx[i] = dout;
         #200 sclk = 1'b0;
      end
      #200 cs_n = 1'b1;
      din = ~din;
      #800;
   endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
// Bench: register port over AXI4-Lite and fault sequences over the link.
// Assumes host_model beside it and a pull-up on the fault pin.
`default_nettype none
`include "fault_report_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, fault_raw;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, irq;
   logic arvalid, arready, rvalid, rready, fault_int_n_o, fault_int_oe;
   logic spi_sclk, spi_cs_n, spi_din, spi_dout, spi_dout_oe;
   logic [15:0] rx;
   wire fault_int_n_i = fault_int_oe ? fault_int_n_o : 1'b1;
   int n_mismatch = 0;
   int n_checks = 0;
   // Per step: fault levels, frame flag, expected pin level, readback.
   localparam logic [27:0] stp [16] = '{
      28'h4000000, 28'h0000000,
      28'h0110280, 28'h0110280,
      28'h0110000, 28'h4000000,
      28'h4110080, 28'h0110280,
      28'h0110000, 28'h2000000,
      28'h0110040, 28'h2110040,
      28'h2110040, 28'ha000000,
      28'h0110300, 28'h2000000};
   fault_report_latch dut (.*);
   host_model host (.sclk(spi_sclk), .cs_n(spi_cs_n), .din(spi_din),
                    .dout(spi_dout_oe ? spi_dout : 1'b1));
   always #25 aclk = ~aclk;
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Ready and valid are read at the falling edge, where they have settled.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      logic ta, tw, hb;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = awvalid & awready;
         tw = wvalid & wready;
         hb = bvalid;
         if (hb) chk("bresp", {30'h0, bresp}, {30'h0, er});
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!hb);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      logic ta, dv;
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(negedge aclk);
         ta = arvalid & arready;
         dv = rvalid;
         if (dv) chk("rdata", rdata, ed);
         if (dv) chk("rresp", {30'h0, rresp}, {30'h0, er});
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end while (!dv);
   endtask
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, arvalid, fault_raw} = '0;
      {bready, rready, wstrb} = 6'h3f;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(`REG_CTRL, 32'h1, `RESP_OKAY);
      rd(`REG_MASK, 32'h0, `RESP_OKAY);
      wr(`REG_MASK, 32'h1, `RESP_OKAY);
      wr(8'h10, 32'h0, `RESP_SLVERR);
      rd(`REG_MASK, 32'h1, `RESP_OKAY);
      rd(8'h10, 32'h0, `RESP_SLVERR);
      $display("test registers done");
      for (int i = 0; i < 16; i++) begin
         fault_raw <= stp[i][27:24];
         repeat (10) @(posedge aclk);
         if (stp[i][20]) begin
            host.frame(16'h2000, rx);
            chk("readback", {16'h0, rx}, {16'h0, stp[i][15:0]});
            repeat (10) @(posedge aclk);
         end
         chk("fault pin", {31'h0, fault_int_n_i}, {31'h0, stp[i][16]});
         if (i == 0) begin
            chk("irq set", {31'h0, irq}, 32'h1);
            wr(`REG_STATUS, 32'h7, `RESP_OKAY);
            chk("irq clear", {31'h0, irq}, 32'h0);
         end
      end
      // Another command must read zeros and leave the fault state alone.
      wr(`REG_STATUS, 32'h7, `RESP_OKAY);
      host.frame(16'h2800, rx);
      chk("other command", {16'h0, rx}, 32'h0);
      repeat (10) @(posedge aclk);
      rd(`REG_STATUS, 32'h4, `RESP_OKAY);
      rd(`REG_FAULT_STATE, 32'h20a, `RESP_OKAY);
      chk("pin kept", {31'h0, fault_int_n_i}, 32'h0);
      $display("test fault sequences done");
      close_out();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      close_out();
   end
endmodule
`default_nettype wire
